// ---- hw/data_area_defs.vh ----
`ifndef DATA_AREA_DEFS_VH
`define DATA_AREA_DEFS_VH

// Area depths and highest legal word, bit and number indices
`define HOLD_DEPTH      100
`define LINK_DEPTH      64
`define TC_DEPTH        512
`define TEMP_DEPTH      8
`define HOLD_LAST       7'h63
`define LINK_LAST       7'h3f
`define BIT_LAST        7'h0f
`define TEMP_LAST       7'h07
`define TC_LAST         10'h1ff

// Area select codes on the access port
`define AREA_HOLD       2'h0
`define AREA_LINK       2'h1
`define AREA_TC         2'h2
`define AREA_TEMP       2'h3

// Instruction class on the access port
`define INSTR_OTHER     2'h0
`define INSTR_LOAD      2'h1
`define INSTR_COIL      2'h2

// Link network that delivered a received word
`define NET_BASIC       2'h0

// Program memory capacity in words
`define PROG_WORDS_4K   14'h1000
`define PROG_WORDS_8K   14'h2000

// Constants for arithmetic on the access path
`define WORD_ZERO       16'h0000
`define WORD_ONE        16'h0001
`define DIGIT_LAST      4'h9

`endif

// ---- hw/bcd_addr_decode.v ----
`timescale 1ns/1ps
`default_nettype none

`include "data_area_defs.vh"

module bcd_addr_decode (
    input  wire [15:0] addr_i,
    output wire [6:0]  hi_o,
    output wire [6:0]  lo_o,
    output wire [9:0]  num_o,
    output wire        digits_ok_o
);

    wire [3:0] d3;
    wire [3:0] d2;
    wire [3:0] d1;
    wire [3:0] d0;
    wire [9:0] n2;
    wire [9:0] n1;
    wire [9:0] n0;
    wire [6:0] h3;
    wire [6:0] h2;
    wire [6:0] l1;
    wire [6:0] l0;

    assign d3 = addr_i[15:12];
    assign d2 = addr_i[11:8];
    assign d1 = addr_i[7:4];
    assign d0 = addr_i[3:0];

    assign digits_ok_o = (d3 <= `DIGIT_LAST) && (d2 <= `DIGIT_LAST) &&
                         (d1 <= `DIGIT_LAST) && (d0 <= `DIGIT_LAST);

    // Upper two digits give the word, lower two the bit
    assign h3   = {3'h0, d3};
    assign h2   = {3'h0, d2};
    assign l1   = {3'h0, d1};
    assign l0   = {3'h0, d0};
    assign hi_o = (h3 << 3) + (h3 << 1) + h2;
    assign lo_o = (l1 << 3) + (l1 << 1) + l0;

    // Three-digit number for the timer/counter area
    assign n2    = {6'h00, d2};
    assign n1    = {6'h00, d1};
    assign n0    = {6'h00, d0};
    assign num_o = (n2 << 6) + (n2 << 5) + (n2 << 2) + (n1 << 3) + (n1 << 1) + n0;

endmodule

`default_nettype wire

// ---- hw/controller_data_area_store.v ----
// Notes on behaviour
// - Holding area has words 00-99, bits 0000-9915, word or bit access.
// - Holding contents survive mode change, power interruption and stop.
// - 512 timer/counter numbers each hold flag, set value, present value.
// - Program check flags any timer/counter number defined twice.
// - Bit operand returns completion flag; word operand returns present value.
// - Set values are kept across power interruption.
// - Timer present values clear at run start and interlock reset.
// - Counter present values keep their count through those events.
// - Link area has words 00-63, bits 0000-6315, word or bit access.
// - Own write words go out to peers; peer words land as read words.
// - Own write words and unclaimed work words are writable; other link words read only.
// - Link area clears on power loss and program mode entry; interlock reset clears one word.
// - Link words unclaimed by the basic link serve as work words.
// - Other networks use the link area only while the basic link idles.
// - Program memory is 4K or 8K words by memory unit type.
// - Eight temporary branch bits, only for load and coil instructions.
`timescale 1ns/1ps
`default_nettype none

`include "data_area_defs.vh"

module controller_data_area_store (
    input  wire        clk_i,
    input  wire        rst_b_i,
    // Operand access from the instruction engine
    input  wire        acc_req_i,
    input  wire [1:0]  acc_area_i,
    input  wire        acc_bit_i,
    input  wire        acc_wr_i,
    input  wire [1:0]  acc_instr_i,
    input  wire [15:0] acc_addr_i,
    input  wire [15:0] acc_wdata_i,
    input  wire        acc_wbit_i,
    output reg         acc_ack_o,
    output reg         acc_err_o,
    output reg  [15:0] acc_rdata_o,
    output reg         acc_rbit_o,
    // Timer/counter definitions and program check
    input  wire        chk_start_i,
    input  wire        def_i,
    input  wire [8:0]  def_num_i,
    input  wire        def_counter_i,
    output reg         dup_err_o,
    // Timer/counter updates from the timing logic
    input  wire        tc_upd_i,
    input  wire [8:0]  tc_upd_num_i,
    input  wire [15:0] tc_upd_pv_i,
    input  wire        tc_upd_flag_i,
    // Set value port for a programming device
    input  wire        sv_wr_i,
    input  wire [8:0]  sv_num_i,
    input  wire [15:0] sv_wdata_i,
    output reg  [15:0] sv_rdata_o,
    // Operating events
    input  wire        run_start_i,
    input  wire        pwr_fail_i,
    input  wire        mode_prog_i,
    input  wire        il_tc_reset_i,
    input  wire [8:0]  il_tc_num_i,
    input  wire        il_link_reset_i,
    input  wire [5:0]  il_link_word_i,
    // Link network
    input  wire [63:0] link_own_mask_i,
    input  wire [63:0] link_claim_mask_i,
    input  wire        link_basic_active_i,
    input  wire        link_rx_i,
    input  wire [1:0]  link_rx_net_i,
    input  wire [5:0]  link_rx_word_i,
    input  wire [15:0] link_rx_data_i,
    output reg         link_tx_o,
    output reg  [5:0]  link_tx_word_o,
    output reg  [15:0] link_tx_data_o,
    // Program memory size
    input  wire        mem_unit_8k_i,
    output reg  [13:0] prog_words_o
);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    reg [15:0] hold_q   [0:`HOLD_DEPTH-1];
    reg [15:0] link_q   [0:`LINK_DEPTH-1];
    reg [15:0] tc_pv_q  [0:`TC_DEPTH-1];
    reg [15:0] tc_sv_q  [0:`TC_DEPTH-1];
    reg [`TC_DEPTH-1:0]   tc_flag_q;
    reg [`TC_DEPTH-1:0]   tc_cnt_q;
    reg [`TC_DEPTH-1:0]   tc_def_q;
    reg [`TEMP_DEPTH-1:0] temp_q;
    reg        mode_prog_q;
    reg        strap_done_q;

    integer    i;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    wire [6:0] hi;
    wire [6:0] lo;
    wire [9:0] num;
    wire       digits_ok;

    bcd_addr_decode u_dec (
        .addr_i      (acc_addr_i),
        .hi_o        (hi),
        .lo_o        (lo),
        .num_o       (num),
        .digits_ok_o (digits_ok)
    );

    wire [6:0]  word_idx;
    wire [3:0]  bit_idx;
    wire [8:0]  tc_idx;
    wire [2:0]  temp_idx;
    wire [15:0] bit_mask;
    wire        bit_ok;
    reg         addr_ok;

    assign word_idx = acc_bit_i ? hi : lo;
    assign bit_idx  = lo[3:0];
    assign tc_idx   = num[8:0];
    assign temp_idx = lo[2:0];
    assign bit_mask = `WORD_ONE << bit_idx;
    assign bit_ok   = !acc_bit_i || (lo <= `BIT_LAST);

    always @* begin
        case (acc_area_i)
            `AREA_HOLD: addr_ok = (word_idx <= `HOLD_LAST) && bit_ok;
            `AREA_LINK: addr_ok = (word_idx <= `LINK_LAST) && bit_ok;
            `AREA_TC:   addr_ok = (num <= `TC_LAST) && !acc_wr_i;
            `AREA_TEMP: addr_ok = acc_bit_i && (hi == 7'h00) && (lo <= `TEMP_LAST) &&
                                  ((acc_wr_i && acc_instr_i == `INSTR_COIL) ||
                                   (!acc_wr_i && acc_instr_i == `INSTR_LOAD));
            default:    addr_ok = 1'b0;
        endcase
    end

    // Local link writes: own write words, or words the basic link leaves free
    wire [5:0] link_idx;
    wire       link_wr_ok;

    assign link_idx   = word_idx[5:0];
    assign link_wr_ok = link_own_mask_i[link_idx] || !link_claim_mask_i[link_idx];

    wire acc_ok;
    wire acc_go;
    wire hold_wr;
    wire link_wr;
    wire temp_wr;

    assign acc_ok  = digits_ok && addr_ok &&
                     !(acc_wr_i && acc_area_i == `AREA_LINK && !link_wr_ok);
    assign acc_go  = acc_req_i && acc_ok;
    assign hold_wr = acc_go && acc_wr_i && acc_area_i == `AREA_HOLD;
    assign link_wr = acc_go && acc_wr_i && acc_area_i == `AREA_LINK;
    assign temp_wr = acc_go && acc_wr_i && acc_area_i == `AREA_TEMP;

    // Old word and the word after a write, word or single bit
    reg  [15:0] old_word;
    wire [15:0] new_word;

    always @* begin
        case (acc_area_i)
            `AREA_HOLD: old_word = (word_idx <= `HOLD_LAST) ? hold_q[word_idx] : `WORD_ZERO;
            `AREA_LINK: old_word = link_q[link_idx];
            `AREA_TC:   old_word = tc_pv_q[tc_idx];
            default:    old_word = `WORD_ZERO;
        endcase
    end

    assign new_word = acc_bit_i ? ((old_word & ~bit_mask) | (acc_wbit_i ? bit_mask : `WORD_ZERO))
                                : acc_wdata_i;

    ////////////////////////////////////////////////////////////////////////
    // Link clear events

    wire prog_entry;
    wire link_clear;
    wire rx_ok;

    assign prog_entry = mode_prog_i && !mode_prog_q;
    assign link_clear = pwr_fail_i || prog_entry;

    // Peer words only land outside own write words; other nets need idle basic link
    assign rx_ok = link_rx_i && !link_own_mask_i[link_rx_word_i] &&
                   (link_rx_net_i == `NET_BASIC || !link_basic_active_i);

    ////////////////////////////////////////////////////////////////////////
    // Area storage
    // Holding area has no clear path at all, so mode change, power loss and
    // stop leave it untouched; only the chip reset initialises it.

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < `HOLD_DEPTH; i = i + 1) begin
                hold_q[i] <= `WORD_ZERO;
            end
        end else if (hold_wr) begin
            hold_q[word_idx] <= new_word;
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < `LINK_DEPTH; i = i + 1) begin
                link_q[i] <= `WORD_ZERO;
            end
        end else if (link_clear) begin
            for (i = 0; i < `LINK_DEPTH; i = i + 1) begin
                link_q[i] <= `WORD_ZERO;
            end
        end else begin
            if (rx_ok) begin
                link_q[link_rx_word_i] <= link_rx_data_i;
            end
            if (link_wr) begin
                link_q[link_idx] <= new_word;
            end
            if (il_link_reset_i) begin
                link_q[il_link_word_i] <= `WORD_ZERO;
            end
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            temp_q <= 8'h00;
        end else if (temp_wr) begin
            temp_q[temp_idx] <= acc_wbit_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer/counter area
    // Clears come after updates so a run start or interlock reset wins over
    // a timing update in the same cycle; counters skip both of those clears.

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < `TC_DEPTH; i = i + 1) begin
                tc_pv_q[i] <= `WORD_ZERO;
            end
            tc_flag_q <= {`TC_DEPTH{1'b0}};
        end else begin
            if (tc_upd_i) begin
                tc_pv_q[tc_upd_num_i]   <= tc_upd_pv_i;
                tc_flag_q[tc_upd_num_i] <= tc_upd_flag_i;
            end
            if (run_start_i) begin
                for (i = 0; i < `TC_DEPTH; i = i + 1) begin
                    if (!tc_cnt_q[i]) begin
                        tc_pv_q[i]   <= `WORD_ZERO;
                        tc_flag_q[i] <= 1'b0;
                    end
                end
            end
            if (il_tc_reset_i && !tc_cnt_q[il_tc_num_i]) begin
                tc_pv_q[il_tc_num_i]   <= `WORD_ZERO;
                tc_flag_q[il_tc_num_i] <= 1'b0;
            end
        end
    end

    // Set values have no clear path besides chip reset
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < `TC_DEPTH; i = i + 1) begin
                tc_sv_q[i] <= `WORD_ZERO;
            end
            sv_rdata_o <= `WORD_ZERO;
        end else begin
            if (sv_wr_i) begin
                tc_sv_q[sv_num_i] <= sv_wdata_i;
            end
            sv_rdata_o <= tc_sv_q[sv_num_i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Definition table and duplicate check
    // A definition in the cycle of the check start still counts.

    wire dup_hit;

    assign dup_hit = def_i && tc_def_q[def_num_i] && !chk_start_i;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tc_def_q  <= {`TC_DEPTH{1'b0}};
            tc_cnt_q  <= {`TC_DEPTH{1'b0}};
            dup_err_o <= 1'b0;
        end else begin
            if (chk_start_i) begin
                tc_def_q <= {`TC_DEPTH{1'b0}};
            end
            if (def_i) begin
                tc_def_q[def_num_i] <= 1'b1;
                tc_cnt_q[def_num_i] <= def_counter_i;
            end
            dup_err_o <= (dup_err_o && !chk_start_i) || dup_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access answer, one cycle after the request

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_ack_o   <= 1'b0;
            acc_err_o   <= 1'b0;
            acc_rdata_o <= `WORD_ZERO;
            acc_rbit_o  <= 1'b0;
        end else begin
            acc_ack_o <= acc_req_i;
            acc_err_o <= acc_req_i && !acc_ok;
            if (acc_go && !acc_wr_i) begin
                case (acc_area_i)
                    `AREA_TC: begin
                        acc_rdata_o <= tc_pv_q[tc_idx];
                        acc_rbit_o  <= tc_flag_q[tc_idx];
                    end
                    `AREA_TEMP: begin
                        acc_rdata_o <= `WORD_ZERO;
                        acc_rbit_o  <= temp_q[temp_idx];
                    end
                    default: begin
                        acc_rdata_o <= old_word;
                        acc_rbit_o  <= |(old_word & bit_mask);
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outgoing link words
    // Only own write words are sent; a work word write stays local.

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_tx_o      <= 1'b0;
            link_tx_word_o <= 6'h00;
            link_tx_data_o <= `WORD_ZERO;
        end else begin
            link_tx_o <= link_wr && link_own_mask_i[link_idx] && !link_clear;
            if (link_wr) begin
                link_tx_word_o <= link_idx;
                link_tx_data_o <= new_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode edge and memory size strap
    // The strap is caught on the first clock after reset release.

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_prog_q  <= 1'b0;
            strap_done_q <= 1'b0;
            prog_words_o <= `PROG_WORDS_4K;
        end else begin
            mode_prog_q <= mode_prog_i;
            if (!strap_done_q) begin
                strap_done_q <= 1'b1;
                prog_words_o <= mem_unit_8k_i ? `PROG_WORDS_8K : `PROG_WORDS_4K;
            end
        end
    end

endmodule

`default_nettype wire

// ---- tb/controller_data_area_store_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "data_area_defs.vh"
module data_area_checker (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        acc_req_i,
    input wire logic [1:0]  acc_area_i,
    input wire logic        acc_bit_i,
    input wire logic        acc_wr_i,
    input wire logic [1:0]  acc_instr_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic [15:0] acc_wdata_i,
    input wire logic        acc_ack_o,
    input wire logic        acc_err_o,
    input wire logic        pwr_fail_i,
    input wire logic        mode_prog_i,
    input wire logic        il_link_reset_i,
    input wire logic [63:0] link_own_mask_i,
    input wire logic        link_tx_o,
    input wire logic [15:0] link_tx_data_o,
    input wire logic        mem_unit_8k_i,
    input wire logic [13:0] prog_words_o
);
    logic [6:0] lw;
    logic       own_wr;
    ////////////////////////////////////////////////////////////
    assign lw = {3'h0, acc_addr_i[7:4]} * 7'h0a + {3'h0, acc_addr_i[3:0]};
    // Mode entry excluded as a level; its edge may span a reset
    assign own_wr = acc_req_i && acc_area_i == `AREA_LINK && acc_wr_i && !acc_bit_i && acc_addr_i[15:8] == 8'h00
                    && acc_addr_i[7:4] <= `DIGIT_LAST && acc_addr_i[3:0] <= `DIGIT_LAST && lw <= `LINK_LAST
                    && link_own_mask_i[lw[5:0]];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////
    property p_ack_follows; acc_req_i |=> acc_ack_o; endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("no ack");
    property p_ack_cause; acc_ack_o |-> $past(acc_req_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_hold_top; acc_req_i && acc_area_i == `AREA_HOLD && !acc_bit_i && acc_addr_i == 16'h0099 |=> !acc_err_o; endproperty
    a_hold_top: assert property (p_hold_top) else $error("top holding word refused");
    property p_link_range; acc_req_i && acc_area_i == `AREA_LINK && !acc_bit_i && acc_addr_i == 16'h0064 |=> acc_err_o; endproperty
    a_link_range: assert property (p_link_range) else $error("link word 64 accepted");
    property p_bit_range; acc_req_i && acc_bit_i && acc_area_i <= `AREA_LINK && acc_addr_i[7:0] == 8'h16 |=> acc_err_o; endproperty
    a_bit_range: assert property (p_bit_range) else $error("bit 16 accepted");
    property p_tc_no_write; acc_req_i && acc_area_i == `AREA_TC && acc_wr_i |=> acc_ack_o && acc_err_o; endproperty
    a_tc_no_write: assert property (p_tc_no_write) else $error("timer write accepted");
    property p_temp_class; acc_req_i && acc_area_i == `AREA_TEMP && !acc_wr_i && acc_instr_i != `INSTR_LOAD |=> acc_err_o; endproperty
    a_temp_class: assert property (p_temp_class) else $error("branch bit read without load");
    property p_link_tx; own_wr && !pwr_fail_i && !mode_prog_i && !il_link_reset_i |=> link_tx_o && link_tx_data_o == $past(acc_wdata_i); endproperty
    a_link_tx: assert property (p_link_tx) else $error("own write word not sent");
    property p_tx_cause; link_tx_o |-> $past(acc_req_i) && $past(acc_wr_i); endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("send without write");
    property p_prog_words; $past(rst_b_i) && !$past(rst_b_i, 2)
        |-> prog_words_o == ($past(mem_unit_8k_i) ? `PROG_WORDS_8K : `PROG_WORDS_4K); endproperty
    a_prog_words: assert property (p_prog_words) else $error("program size wrong for strap");
endmodule
bind controller_data_area_store data_area_checker u_chk (
    .clk_i, .rst_b_i, .acc_req_i, .acc_area_i, .acc_bit_i, .acc_wr_i, .acc_instr_i, .acc_addr_i, .acc_wdata_i,
    .acc_ack_o, .acc_err_o, .pwr_fail_i, .mode_prog_i, .il_link_reset_i, .link_own_mask_i, .link_tx_o,
    .link_tx_data_o, .mem_unit_8k_i, .prog_words_o);
`default_nettype wire

// ---- tb/link_peer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module link_peer_model (
    input  wire logic        clk_i,
    input  wire logic        tx_i,
    input  wire logic [5:0]  tx_word_i,
    input  wire logic [15:0] tx_data_i,
    output logic             rx_o,
    output logic [1:0]       rx_net_o,
    output logic [5:0]       rx_word_o,
    output logic [15:0]      rx_data_o,
    output logic [5:0]       seen_word_o,
    output logic [15:0]      seen_data_o
);
    initial begin
        {rx_o, rx_net_o, rx_word_o, rx_data_o} = {1'b0, 2'h0, 6'h15, 16'h5a5a};
    end
    // Last word broadcast to us
    always @(posedge clk_i) begin
        if (tx_i === 1'b1) begin
            seen_word_o <= tx_word_i;
            seen_data_o <= tx_data_i;
        end
    end
    // Word and data go inverted once released
    task automatic send(input logic [1:0] net, input logic [5:0] w, input logic [15:0] d);
        {rx_o, rx_net_o, rx_word_o, rx_data_o} = {1'b1, net, w, d};
        @(negedge clk_i);
        {rx_o, rx_word_o, rx_data_o} = {1'b0, ~w, ~d};
    endtask
endmodule
`default_nettype wire

// ---- tb/test_controller_data_area_store.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "data_area_defs.vh"
module test_controller_data_area_store;
    typedef struct packed {logic er; logic [1:0] k; logic [15:0] v;} note_t;
    localparam logic [1:0] H = `AREA_HOLD, L = `AREA_LINK, T = `AREA_TC, B = `AREA_TEMP;
    localparam logic [1:0] O = `INSTR_OTHER, LO = `INSTR_LOAD, C = `INSTR_COIL;
    localparam logic [8:0] E_PWR = 9'h001, E_PROG = 9'h002, E_RUN = 9'h004, E_ILTC = 9'h008, E_ILLK = 9'h010;
    localparam logic [8:0] E_CHK = 9'h020, E_DEF = 9'h040, E_UPD = 9'h080, E_SV = 9'h100;
    logic        clk_i, rst_b_i, acc_req_i, acc_bit_i, acc_wr_i, flag, basic_act, mem_unit_8k_i;
    logic        ack, err, rbit, dup, tx, rx;
    logic [1:0]  acc_area_i, acc_instr_i, rx_net;
    logic [15:0] acc_addr_i, acc_wdata_i, dat, rdata, sv_rd, tx_data, rx_data, seen_data, seed, r, s;
    logic [8:0]  ev, num;
    logic [63:0] own_mask, claim_mask;
    logic [13:0] prog_words;
    logic [5:0]  tx_word, rx_word, seen_word;
    note_t       q[$];
    note_t       n;
    int          fail_count, comparisons, cycles;
    ////////////////////////////////////////////////////////////
    controller_data_area_store DUT (
        .clk_i, .rst_b_i, .acc_req_i, .acc_area_i, .acc_bit_i, .acc_wr_i, .acc_instr_i, .acc_addr_i, .acc_wdata_i,
        .acc_wbit_i(acc_wdata_i[0]), .acc_ack_o(ack), .acc_err_o(err), .acc_rdata_o(rdata), .acc_rbit_o(rbit),
        .chk_start_i(ev[5]), .def_i(ev[6]), .def_num_i(num), .def_counter_i(flag), .dup_err_o(dup),
        .tc_upd_i(ev[7]), .tc_upd_num_i(num), .tc_upd_pv_i(dat), .tc_upd_flag_i(flag), .sv_wr_i(ev[8]),
        .sv_num_i(num), .sv_wdata_i(dat), .sv_rdata_o(sv_rd), .run_start_i(ev[2]), .pwr_fail_i(ev[0]),
        .mode_prog_i(ev[1]), .il_tc_reset_i(ev[3]), .il_tc_num_i(num), .il_link_reset_i(ev[4]),
        .il_link_word_i(num[5:0]), .link_own_mask_i(own_mask), .link_claim_mask_i(claim_mask),
        .link_basic_active_i(basic_act), .link_rx_i(rx), .link_rx_net_i(rx_net), .link_rx_word_i(rx_word),
        .link_rx_data_i(rx_data), .link_tx_o(tx), .link_tx_word_o(tx_word), .link_tx_data_o(tx_data),
        .mem_unit_8k_i, .prog_words_o(prog_words));
    link_peer_model peer (
        .clk_i, .tx_i(tx), .tx_word_i(tx_word), .tx_data_i(tx_data), .rx_o(rx), .rx_net_o(rx_net),
        .rx_word_o(rx_word), .rx_data_o(rx_data), .seen_word_o(seen_word), .seen_data_o(seen_data));
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Request stays up between back-to-back accesses
    task automatic acc(input logic [1:0] ar, input logic bt, wr, input logic [1:0] ins, input logic [15:0] ad, wd,
                       input logic er, input logic [1:0] k, input logic [15:0] v);
        {acc_req_i, ev, acc_area_i, acc_bit_i, acc_wr_i} = {1'b1, 9'h000, ar, bt, wr};
        {acc_instr_i, acc_addr_i, acc_wdata_i} = {ins, ad, wd};
        q.push_back({er, k, v});
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [1:0] ar, input logic [15:0] ad, v);
        acc(ar, 0, 0, O, ad, 0, 0, 1, v);
    endtask
    task automatic pulse(input logic [8:0] m);
        {acc_req_i, ev} = {1'b0, m};
        @(negedge clk_i);
    endtask
    task automatic lk(input logic [1:0] net, input logic [5:0] w, input logic [15:0] d);
        {acc_req_i, ev} = {1'b0, 9'h000};
        peer.send(net, w, d);
    endtask
    ////////////////////////////////////////////////////////////
    always @(negedge clk_i) begin
        if (ack === 1'b1) begin
            if (q.size() == 0) check(16'h0001, 16'h0000);
            else begin
                n = q.pop_front();
                check({15'h0, err}, {15'h0, n.er});
                if (n.k == 2'h1) check(rdata, n.v);
                if (n.k == 2'h2) check({15'h0, rbit}, n.v);
            end
        end
    end
    // Run is under a hundred cycles; wide margin
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        {rst_b_i, acc_req_i, acc_bit_i, acc_wr_i, flag, acc_area_i, acc_instr_i, acc_addr_i, acc_wdata_i} = '0;
        {ev, num, dat, fail_count, comparisons, cycles} = '0;
        own_mask = 64'h8000_0000_0000_0002;
        claim_mask = 64'h0000_0000_0000_0006;
        basic_act = 1'b1;
        mem_unit_8k_i = 1'b1;
        seed = 16'h0022;
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        check({2'h0, prog_words}, {2'h0, `PROG_WORDS_8K});
        seed = lfsr(seed);
        r = seed;
        acc(H, 0, 1, O, 16'h0099, r, 0, 0, 0);
        rd(H, 16'h0099, r);
        acc(H, 1, 1, C, 16'h9915, {15'h0, ~r[15]}, 0, 0, 0);
        rd(H, 16'h0099, {~r[15], r[14:0]});
        acc(H, 1, 0, O, 16'h9915, 0, 0, 2, {15'h0, ~r[15]});
        acc(H, 0, 0, O, 16'h009a, 0, 1, 0, 0);
        acc(H, 1, 0, O, 16'h9916, 0, 1, 0, 0);
        pulse(E_PWR | E_PROG | E_RUN);
        rd(H, 16'h0099, {~r[15], r[14:0]});
        seed = lfsr(seed);
        s = seed;
        acc(L, 0, 1, O, 16'h0063, s, 0, 0, 0);
        acc(L, 0, 1, O, 16'h0002, r, 1, 0, 0);
        acc(L, 0, 1, O, 16'h0005, r, 0, 0, 0);
        rd(L, 16'h0005, r);
        acc(L, 0, 0, O, 16'h0064, 0, 1, 0, 0);
        acc(L, 1, 0, O, 16'h6315, 0, 0, 2, {15'h0, s[15]});
        check({10'h0, seen_word}, 16'h003f);
        check(seen_data, s);
        lk(2'h0, 6'd3, r);
        rd(L, 16'h0003, r);
        lk(2'h0, 6'd63, ~s);
        rd(L, 16'h0063, s);
        lk(2'h1, 6'd4, r);
        rd(L, 16'h0004, 0);
        basic_act = 1'b0;
        lk(2'h1, 6'd4, r);
        rd(L, 16'h0004, r);
        num = 9'd3;
        pulse(E_ILLK);
        rd(L, 16'h0003, 0);
        rd(L, 16'h0004, r);
        pulse(E_PWR);
        rd(L, 16'h0004, 0);
        acc(L, 0, 1, O, 16'h0005, r, 0, 0, 0);
        pulse(E_PROG);
        rd(L, 16'h0005, 0);
        flag = 1'b1;
        pulse(E_CHK);
        num = 9'd5;
        pulse(E_DEF);
        flag = 1'b0;
        num = 9'd6;
        pulse(E_DEF);
        check({15'h0, dup}, 16'h0000);
        pulse(E_DEF);
        check({15'h0, dup}, 16'h0001);
        flag = 1'b1;
        num = 9'd5;
        dat = r;
        pulse(E_UPD);
        num = 9'd6;
        pulse(E_UPD);
        rd(T, 16'h0005, r);
        acc(T, 1, 0, O, 16'h0005, 0, 0, 2, 16'h0001);
        rd(T, 16'h0006, r);
        pulse(E_RUN);
        rd(T, 16'h0006, 0);
        acc(T, 1, 0, O, 16'h0005, 0, 0, 2, 16'h0001);
        pulse(E_UPD);
        pulse(E_ILTC);
        rd(T, 16'h0006, 0);
        num = 9'd5;
        pulse(E_ILTC);
        rd(T, 16'h0005, r);
        acc(T, 0, 1, O, 16'h0005, r, 1, 0, 0);
        acc(T, 0, 0, O, 16'h0512, 0, 1, 0, 0);
        rd(T, 16'h0511, 0);
        num = 9'd511;
        pulse(E_SV);
        pulse(E_PWR);
        check(sv_rd, r);
        acc(B, 1, 1, C, 16'h0007, 16'h0001, 0, 0, 0);
        acc(B, 1, 0, LO, 16'h0007, 0, 0, 2, 16'h0001);
        acc(B, 1, 0, O, 16'h0007, 0, 1, 0, 0);
        acc(B, 1, 0, LO, 16'h0008, 0, 1, 0, 0);
        acc(B, 0, 0, LO, 16'h0007, 0, 1, 0, 0);
        acc(B, 1, 1, LO, 16'h0006, 16'h0001, 1, 0, 0);
        acc(B, 1, 0, LO, 16'h0006, 0, 0, 2, 16'h0000);
        pulse(9'h000);
        rst_b_i = 1'b0;
        mem_unit_8k_i = 1'b0;
        pulse(9'h000);
        rst_b_i = 1'b1;
        pulse(9'h000);
        check({2'h0, prog_words}, {2'h0, `PROG_WORDS_4K});
        check(16'(q.size()), 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
